// File: cbc_lane_split.sv
/*
 * Byte-lane planner for one operand on a 16-bit data bus.
 * Assumes a byte or word operand at any byte address; purely combinational.
 */
`timescale 1ns/1ps
module cbc_lane_split #(
	parameter int ADDR_W = 24
) (
	input wire logic [ADDR_W-1:0] addr_in,
	input wire logic word_in,
	input wire logic half_in,
	output logic [ADDR_W-2:0] word_addr_out,
	output logic high_byte_enable_n_out,
	output logic low_byte_enable_n_out,
	output logic two_out,
	output logic [1:0] sel_out
);
	// sel_out: 0 whole word, 1 low lane/low byte, 2 high lane/low byte, 3 low lane/high byte
	always_comb begin
		two_out = word_in & addr_in[0];
		word_addr_out = addr_in[ADDR_W-1:1];
		if (!word_in) begin
			sel_out = addr_in[0] ? 2'h2 : 2'h1;
			high_byte_enable_n_out = ~addr_in[0];
			low_byte_enable_n_out = addr_in[0];
		end else if (!addr_in[0]) begin
			sel_out = 2'h0;
			high_byte_enable_n_out = 1'b0;
			low_byte_enable_n_out = 1'b0;
		end else if (!half_in) begin
			sel_out = 2'h2;
			high_byte_enable_n_out = 1'b0;
			low_byte_enable_n_out = 1'b1;
		end else begin
			sel_out = 2'h3;
			high_byte_enable_n_out = 1'b1;
			low_byte_enable_n_out = 1'b0;
			word_addr_out = addr_in[ADDR_W-1:1] + {{(ADDR_W-2){1'b0}}, 1'b1};
		end
	end
endmodule : cbc_lane_split

// File: cbc_bus_cycle.sv
/*
 * Package and bus cycle engine of a 16-bit-data, 24-bit-address processor bus.
 * Assumes clk_in is the double-rate clock (two periods per bus state) and that
 * all pin inputs are synchronous to it; the core hands in one operand at a time.
 */
// Summary of operation
// - Reset ignores inputs except float, aborts all
// - Reset drives idle pin pattern
// - Reset overrides hold and hold acknowledge
// - Reset is synchronous active-high level
// - Unaligned word splits into two cycles
// - Byte enables follow active data lanes
// - I/O up to 00FFFFH, memory full range
// - Coprocessor I/O at 8000F8H to 8000FFH
// - Eight cycle kinds with lock rules
// - Address strobe marks every new address
// - Idle means cycle ended, no strobe since
// - Hold acknowledge high throughout hold state
// - Bus state two clocks, cycle two states
// - Ready sampled end of second state, waits
// - Next-address input selects pipelined addressing
// - First cycle after idle never pipelined
// - Pipelined cycles also need two states
// - Read data captured when ready acknowledges
// - Write data held through next phase one
// - Write data driven from first-state phase two
// - Every cycle starts first-state then second-state
package cbc_pkg;
	localparam logic [23:0] IO_ADDR_MASK = 24'h00FFFF;
	localparam logic [23:0] COPRO_BASE = 24'h8000F8;
	localparam logic [22:0] RST_ADDR = 23'h7FFFFF;
	localparam logic RST_ADS_N = 1'b1;
	localparam logic RST_BE_N = 1'b0;
	localparam logic RST_W_R = 1'b0;
	localparam logic RST_D_C = 1'b1;
	localparam logic RST_M_IO = 1'b0;
	localparam logic RST_LOCK_N = 1'b1;
	typedef enum logic [2:0] {
		ST_IDLE = 3'h0, ST_FIRST = 3'h1, ST_SECOND = 3'h2, ST_PFIRST = 3'h3,
		ST_PSECOND = 3'h4, ST_SECOND_IDLE = 3'h5, ST_HOLD = 3'h6
	} cbc_state_t;
	typedef enum logic [2:0] {
		K_MEM_RD = 3'h0, K_MEM_RD_LOCK = 3'h1, K_MEM_WR = 3'h2, K_MEM_WR_LOCK = 3'h3,
		K_IO_RD = 3'h4, K_IO_WR = 3'h5, K_INTA = 3'h6, K_HALT = 3'h7
	} cbc_kind_t;
endpackage : cbc_pkg

`timescale 1ns/1ps
module cbc_bus_cycle #(
	parameter int ADDR_W = 24,
	parameter int DATA_W = 16
) (
	input wire logic clk_in,
	input wire logic srst_in,
	input wire logic req_valid_in,
	input wire logic [2:0] req_kind_in,
	input wire logic [ADDR_W-1:0] req_addr_in,
	input wire logic req_word_in,
	input wire logic req_copro_in,
	input wire logic [DATA_W-1:0] req_wdata_in,
	output logic req_ready_out,
	output logic rsp_valid_out,
	output logic [DATA_W-1:0] rsp_rdata_out,
	output logic address_strobe_n_out,
	output logic [ADDR_W-2:0] upper_address_lines_out,
	output logic high_byte_enable_n_out,
	output logic low_byte_enable_n_out,
	output logic w_r_out,
	output logic d_c_out,
	output logic m_io_out,
	output logic lock_n_out,
	output logic hold_acknowledge_out,
	output logic bus_oe_out,
	input wire logic [DATA_W-1:0] data_lines_in,
	output logic [DATA_W-1:0] data_lines_out,
	output logic data_lines_oe_out,
	input wire logic ready_n_in,
	input wire logic next_address_request_n_in,
	input wire logic hold_request_in,
	input wire logic bus_float_input_n_in
);
	generate
		if (ADDR_W != 24 || DATA_W != 16) begin : g_bad_width
			$error("cbc_bus_cycle serves only a 24-bit address and 16-bit data bus");
		end
	endgenerate

	// ----------------------------------------------------------------
	// Phase and state
	// ----------------------------------------------------------------
	cbc_pkg::cbc_state_t st_reg, st_next;
	logic ph_reg;
	logic na_seen_reg;
	logic issue, pipe, ack;

	// Operand slot
	logic op_valid_reg, op_half_reg, op_copro_reg, op_word_reg;
	logic [2:0] op_kind_reg;
	logic [ADDR_W-1:0] op_addr_reg;
	logic [DATA_W-1:0] op_wdata_reg;

	// Cycle in data phase and cycle already addressed ahead of it
	logic cur_wr_reg, cur_rd_reg, cur_last_reg, nxt_wr_reg, nxt_rd_reg, nxt_last_reg;
	logic [1:0] cur_sel_reg, nxt_sel_reg;
	logic [DATA_W-1:0] cur_wdata_reg, nxt_wdata_reg, acc_reg, acc_next;

	logic [ADDR_W-1:0] eff_addr;
	logic [ADDR_W-2:0] ln_addr;
	logic ln_bhe_n, ln_ble_n, ln_two;
	logic [1:0] ln_sel;
	logic is_wr, is_rd, is_lock;

	// Clock is the double rate: bus state = two phases
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			ph_reg <= 1'b0;
		end else begin
			ph_reg <= ~ph_reg;
		end
	end

	always_comb begin
		st_next = st_reg;
		issue = 1'b0;
		pipe = 1'b0;
		ack = 1'b0;
		if (ph_reg) begin
			case (st_reg)
				cbc_pkg::ST_IDLE, cbc_pkg::ST_HOLD: begin
					if (hold_request_in) begin
						st_next = cbc_pkg::ST_HOLD;
					end else if (op_valid_reg) begin
						st_next = cbc_pkg::ST_FIRST;
						issue = 1'b1;
					end else begin
						st_next = cbc_pkg::ST_IDLE;
					end
				end
				cbc_pkg::ST_FIRST: st_next = cbc_pkg::ST_SECOND;
				cbc_pkg::ST_PFIRST, cbc_pkg::ST_SECOND, cbc_pkg::ST_SECOND_IDLE: begin
					ack = ~ready_n_in && (st_reg != cbc_pkg::ST_PFIRST);
					if (ack) begin
						if (hold_request_in) begin
							st_next = cbc_pkg::ST_HOLD;
						end else if (op_valid_reg) begin
							st_next = cbc_pkg::ST_FIRST;
							issue = 1'b1;
						end else begin
							st_next = cbc_pkg::ST_IDLE;
						end
					end else if (na_seen_reg && op_valid_reg) begin
						st_next = cbc_pkg::ST_PSECOND;
						issue = 1'b1;
						pipe = 1'b1;
					end else if (na_seen_reg) begin
						st_next = cbc_pkg::ST_SECOND_IDLE;
					end else begin
						st_next = cbc_pkg::ST_SECOND;
					end
				end
				cbc_pkg::ST_PSECOND: begin
					ack = ~ready_n_in;
					if (ack) begin
						st_next = cbc_pkg::ST_PFIRST;
					end
				end
				default: st_next = cbc_pkg::ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			st_reg <= cbc_pkg::ST_IDLE;
			hold_acknowledge_out <= 1'b0;
		end else if (ph_reg) begin
			st_reg <= st_next;
			hold_acknowledge_out <= (st_next == cbc_pkg::ST_HOLD);
		end
	end

	// Next-address sampled at end of phase one once the address is a state old
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			na_seen_reg <= 1'b0;
		end else if (!ph_reg) begin
			if ((st_reg == cbc_pkg::ST_SECOND || st_reg == cbc_pkg::ST_PFIRST ||
				st_reg == cbc_pkg::ST_SECOND_IDLE) && !next_address_request_n_in) begin
				na_seen_reg <= 1'b1;
			end
		end else if (st_next != cbc_pkg::ST_SECOND && st_next != cbc_pkg::ST_SECOND_IDLE) begin
			na_seen_reg <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Operand slot and cycle decode
	// ----------------------------------------------------------------
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			op_valid_reg <= 1'b0;
			op_half_reg <= 1'b0;
			req_ready_out <= 1'b0;
		end else if (!op_valid_reg) begin
			req_ready_out <= 1'b1;
			if (req_valid_in && req_ready_out) begin
				op_valid_reg <= 1'b1;
				op_half_reg <= 1'b0;
				req_ready_out <= 1'b0;
			end
		end else if (issue) begin
			if (ln_two && !op_half_reg) begin
				op_half_reg <= 1'b1;
			end else begin
				op_valid_reg <= 1'b0;
				req_ready_out <= 1'b1;
			end
		end
	end

	always_ff @(posedge clk_in) begin
		if (!op_valid_reg && req_valid_in && req_ready_out) begin
			op_kind_reg <= req_kind_in;
			op_addr_reg <= req_addr_in;
			op_word_reg <= req_word_in;
			op_copro_reg <= req_copro_in;
			op_wdata_reg <= req_wdata_in;
		end
	end

	always_comb begin
		is_wr = (op_kind_reg == cbc_pkg::K_MEM_WR) || (op_kind_reg == cbc_pkg::K_MEM_WR_LOCK) ||
			(op_kind_reg == cbc_pkg::K_IO_WR);
		is_rd = (op_kind_reg == cbc_pkg::K_MEM_RD) || (op_kind_reg == cbc_pkg::K_MEM_RD_LOCK) ||
			(op_kind_reg == cbc_pkg::K_IO_RD) || (op_kind_reg == cbc_pkg::K_INTA);
		is_lock = (op_kind_reg == cbc_pkg::K_MEM_RD_LOCK) ||
			(op_kind_reg == cbc_pkg::K_MEM_WR_LOCK) || (op_kind_reg == cbc_pkg::K_INTA);
		eff_addr = op_addr_reg;
		if (op_kind_reg == cbc_pkg::K_IO_RD || op_kind_reg == cbc_pkg::K_IO_WR) begin
			if (op_copro_reg) begin
				eff_addr = cbc_pkg::COPRO_BASE | {21'h000000, op_addr_reg[2:0]};
			end else begin
				eff_addr = op_addr_reg & cbc_pkg::IO_ADDR_MASK;
			end
		end
	end

	cbc_lane_split #(
		.ADDR_W(ADDR_W)
	) u_lane (
		.addr_in(eff_addr),
		.word_in(op_word_reg),
		.half_in(op_half_reg),
		.word_addr_out(ln_addr),
		.high_byte_enable_n_out(ln_bhe_n),
		.low_byte_enable_n_out(ln_ble_n),
		.two_out(ln_two),
		.sel_out(ln_sel)
	);

	// ----------------------------------------------------------------
	// Address and definition pins
	// ----------------------------------------------------------------
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			address_strobe_n_out <= cbc_pkg::RST_ADS_N;
			upper_address_lines_out <= cbc_pkg::RST_ADDR;
			high_byte_enable_n_out <= cbc_pkg::RST_BE_N;
			low_byte_enable_n_out <= cbc_pkg::RST_BE_N;
			w_r_out <= cbc_pkg::RST_W_R;
			d_c_out <= cbc_pkg::RST_D_C;
			m_io_out <= cbc_pkg::RST_M_IO;
			lock_n_out <= cbc_pkg::RST_LOCK_N;
		end else if (ph_reg) begin
			address_strobe_n_out <= ~issue;
			if (issue) begin
				upper_address_lines_out <= ln_addr;
				high_byte_enable_n_out <= ln_bhe_n;
				low_byte_enable_n_out <= ln_ble_n;
				w_r_out <= is_wr || (op_kind_reg == cbc_pkg::K_HALT);
				d_c_out <= (op_kind_reg != cbc_pkg::K_INTA) && (op_kind_reg != cbc_pkg::K_HALT);
				m_io_out <= ~op_kind_reg[2] || (op_kind_reg == cbc_pkg::K_HALT);
				lock_n_out <= ~is_lock;
			end
		end
	end

	always_ff @(posedge clk_in) begin
		bus_oe_out <= bus_float_input_n_in;
	end

	// ----------------------------------------------------------------
	// Data phase tracking
	// ----------------------------------------------------------------
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			cur_wr_reg <= 1'b0;
			cur_rd_reg <= 1'b0;
			cur_last_reg <= 1'b0;
			nxt_wr_reg <= 1'b0;
			nxt_rd_reg <= 1'b0;
			nxt_last_reg <= 1'b0;
		end else if (ph_reg) begin
			if (issue && pipe) begin
				nxt_wr_reg <= is_wr;
				nxt_rd_reg <= is_rd;
				nxt_last_reg <= ~(ln_two && !op_half_reg);
				nxt_sel_reg <= ln_sel;
				nxt_wdata_reg <= op_wdata_reg;
			end else if (issue) begin
				cur_wr_reg <= is_wr;
				cur_rd_reg <= is_rd;
				cur_last_reg <= ~(ln_two && !op_half_reg);
				cur_sel_reg <= ln_sel;
				cur_wdata_reg <= op_wdata_reg;
			end else if (ack && st_reg == cbc_pkg::ST_PSECOND) begin
				cur_wr_reg <= nxt_wr_reg;
				cur_rd_reg <= nxt_rd_reg;
				cur_last_reg <= nxt_last_reg;
				cur_sel_reg <= nxt_sel_reg;
				cur_wdata_reg <= nxt_wdata_reg;
			end
		end
	end

	// Write drive: from phase two of the first state to end of phase one after ack
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			data_lines_oe_out <= 1'b0;
			data_lines_out <= '0;
		end else if (!ph_reg) begin
			if (st_reg == cbc_pkg::ST_FIRST || st_reg == cbc_pkg::ST_PFIRST) begin
				data_lines_oe_out <= cur_wr_reg && bus_float_input_n_in;
				case (cur_sel_reg)
					2'h0: data_lines_out <= cur_wdata_reg;
					2'h3: data_lines_out <= {cur_wdata_reg[15:8], cur_wdata_reg[15:8]};
					default: data_lines_out <= {cur_wdata_reg[7:0], cur_wdata_reg[7:0]};
				endcase
			end else if (st_reg == cbc_pkg::ST_IDLE || st_reg == cbc_pkg::ST_HOLD) begin
				data_lines_oe_out <= 1'b0;
			end else if (!bus_float_input_n_in) begin
				data_lines_oe_out <= 1'b0;
			end
		end else if (!bus_float_input_n_in) begin
			data_lines_oe_out <= 1'b0;
		end
	end

	// Read capture at the acknowledging edge
	always_comb begin
		acc_next = acc_reg;
		case (cur_sel_reg)
			2'h0: acc_next = data_lines_in;
			2'h1: acc_next[7:0] = data_lines_in[7:0];
			2'h2: acc_next[7:0] = data_lines_in[15:8];
			2'h3: acc_next[15:8] = data_lines_in[7:0];
			default: acc_next = acc_reg;
		endcase
	end

	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			acc_reg <= '0;
			rsp_valid_out <= 1'b0;
			rsp_rdata_out <= '0;
		end else begin
			rsp_valid_out <= ack && cur_last_reg;
			if (ack && cur_rd_reg) begin
				acc_reg <= acc_next;
				if (cur_last_reg) begin
					rsp_rdata_out <= acc_next;
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	property p_reset_pins;
		@(posedge clk_in) srst_in |=> address_strobe_n_out && !w_r_out && d_c_out && !m_io_out
			&& lock_n_out && !hold_acknowledge_out && !data_lines_oe_out
			&& (&upper_address_lines_out) && !high_byte_enable_n_out;
	endproperty
	a_reset_pins: assert property (p_reset_pins) else $error("idle pins wrong after reset");

	property p_reset_over_hold;
		@(posedge clk_in) srst_in && hold_request_in |=> !hold_acknowledge_out
			&& st_reg == cbc_pkg::ST_IDLE;
	endproperty
	a_reset_over_hold: assert property (p_reset_over_hold) else $error("hold beat reset");

	property p_state_len;
		@(posedge clk_in) disable iff (srst_in) $changed(st_reg) |-> !ph_reg;
	endproperty
	a_state_len: assert property (p_state_len) else $error("bus state shorter than two clocks");

	property p_first_second;
		@(posedge clk_in) disable iff (srst_in)
			st_reg == cbc_pkg::ST_FIRST && ph_reg |=> st_reg == cbc_pkg::ST_SECOND;
	endproperty
	a_first_second: assert property (p_first_second) else $error("first state not followed");

	property p_strobe;
		@(posedge clk_in) disable iff (srst_in) $fell(address_strobe_n_out) |->
			(st_reg == cbc_pkg::ST_FIRST || st_reg == cbc_pkg::ST_PSECOND) ##1
			!address_strobe_n_out;
	endproperty
	a_strobe: assert property (p_strobe) else $error("strobe without new address");

	property p_after_idle;
		@(posedge clk_in) disable iff (srst_in) $past(st_reg) == cbc_pkg::ST_IDLE
			&& st_reg != cbc_pkg::ST_IDLE |-> st_reg inside {cbc_pkg::ST_FIRST, cbc_pkg::ST_HOLD};
	endproperty
	a_after_idle: assert property (p_after_idle) else $error("pipelined cycle after idle");

	property p_wait;
		@(posedge clk_in) disable iff (srst_in) st_reg == cbc_pkg::ST_SECOND && ph_reg
			&& ready_n_in |=> st_reg inside {cbc_pkg::ST_SECOND, cbc_pkg::ST_PSECOND,
			cbc_pkg::ST_SECOND_IDLE};
	endproperty
	a_wait: assert property (p_wait) else $error("cycle ended without ready");

	property p_write_drive;
		@(posedge clk_in) disable iff (srst_in) st_reg == cbc_pkg::ST_FIRST && !ph_reg
			&& cur_wr_reg && bus_float_input_n_in |=> data_lines_oe_out [*2];
	endproperty
	a_write_drive: assert property (p_write_drive) else $error("write data not driven");

	property p_read_rsp;
		@(posedge clk_in) disable iff (srst_in) ack && cur_rd_reg && cur_last_reg |=>
			rsp_valid_out && rsp_rdata_out == $past(acc_next);
	endproperty
	a_read_rsp: assert property (p_read_rsp) else $error("read data not captured");

	property p_hold_ack;
		@(posedge clk_in) disable iff (srst_in)
			hold_acknowledge_out == (st_reg == cbc_pkg::ST_HOLD);
	endproperty
	a_hold_ack: assert property (p_hold_ack) else $error("hold acknowledge mismatch");

	property p_io_range;
		@(posedge clk_in) disable iff (srst_in) !address_strobe_n_out && !m_io_out && d_c_out
			|-> upper_address_lines_out[22] ? upper_address_lines_out[22:2] ==
			cbc_pkg::COPRO_BASE[23:3] : upper_address_lines_out[22:15] == 8'h00;
	endproperty
	a_io_range: assert property (p_io_range) else $error("I/O address out of range");
endmodule : cbc_bus_cycle

// File: cbc_partner.sv
/* Far-side memory and bus-control model for the bus cycle engine.
   Assumes engine pins change on clk_in edges; reset is synchronous. */
`timescale 1ns/1ps
module cbc_partner (
	input wire logic clk_in,
	input wire logic srst_in,
	input wire logic ads_n_in,
	input wire logic [22:0] addr_in,
	input wire logic [1:0] be_n_in,
	input wire logic w_r_in,
	input wire logic d_c_in,
	input wire logic [15:0] dq_in,
	input wire logic dq_oe_in,
	input wire logic [1:0] wait_in,
	output logic ready_n_out,
	output logic [15:0] dq_out,
	output logic [7:0] err_out
);
	logic [7:0] mem [logic [23:0]];
	logic [26:0] q [$];
	logic [26:0] hd;
	logic ads_prev_reg, ph2_reg, hchk_reg, rd_reg;
	logic [2:0] cnt_reg;
	logic [1:0] wt_reg;
	logic [15:0] last_reg, rw_reg;
	logic [7:0] err_reg = 8'h00;

	function automatic logic [7:0] rb(input logic [23:0] a);
		return mem.exists(a) ? mem[a] : (a[7:0] ^ 8'h5A);
	endfunction : rb

	// Released lines show read data during a read, else the inverse of their last level
	assign dq_out = dq_oe_in ? dq_in : (rd_reg ? rw_reg : ~last_reg);
	assign err_out = err_reg;

	// ----------------------------------------
	// Cycle tracking, phase follows the strobe
	// ----------------------------------------
	always @(posedge clk_in) begin
		ads_prev_reg <= ads_n_in;
		last_reg <= dq_out;
		if (srst_in) begin
			q.delete();
			ph2_reg = 1'b0;
			hchk_reg = 1'b0;
			rd_reg <= 1'b0;
			ready_n_out <= 1'b1;
		end else begin
			if (hchk_reg && dq_oe_in !== 1'b1) err_reg <= err_reg + 8'h01;
			hchk_reg = 1'b0;
			if (ph2_reg && q.size() > 0) begin
				if (ready_n_out === 1'b0) begin
					hd = q.pop_front();
					if (hd[26] && hd[25]) begin
						if (dq_oe_in !== 1'b1) err_reg <= err_reg + 8'h01;
						if (!hd[24]) mem[{hd[22:0], 1'b1}] = dq_out[15:8];
						if (!hd[23]) mem[{hd[22:0], 1'b0}] = dq_out[7:0];
						hchk_reg = 1'b1;
					end
					cnt_reg = 3'h0;
					wt_reg = wait_in;
				end else begin
					cnt_reg = cnt_reg + 3'h1;
				end
			end
			if (ads_prev_reg && !ads_n_in) begin
				if (q.size() == 0) begin
					cnt_reg = 3'h0;
					wt_reg = wait_in;
				end
				q.push_back({d_c_in, w_r_in, be_n_in, addr_in});
				ph2_reg = 1'b1;
			end else begin
				ph2_reg = !ph2_reg;
			end
			hd = (q.size() > 0) ? q[0] : 27'h0;
			rd_reg <= (q.size() > 0) && !hd[25];
			rw_reg <= {rb({hd[22:0], 1'b1}), rb({hd[22:0], 1'b0})};
			// Ready only from the second state on, after the chosen waits
			ready_n_out <= !((q.size() > 0) && ({1'b0, cnt_reg} >= 4'h1 + {2'h0, wt_reg}));
		end
	end
endmodule : cbc_partner

// File: testbench.sv
/* Self-checking bench for the bus cycle engine with random operand traffic.
   Assumes cbc_partner on the far side and the engine's default widths. */
`timescale 1ns/1ps
module testbench;
	localparam logic [31:0] DEF_TAB = 32'hB075EFCD;
	logic clk_in, srst_in, rq_v, rq_w, rq_cp, rq_rdy, rs_v, ads_n, hbe_n, lbe_n, w_r, d_c;
	logic m_io, lock_n, hold_acknowledge, bus_oe, dq_oe, rdy_n, na_n, hold, flt_n;
	logic [2:0] rq_k;
	logic [23:0] rq_a;
	logic [15:0] rq_d, rs_d, dq_o, dq_i;
	logic [22:0] ua;
	logic [1:0] wt;
	logic [7:0] p_err;
	logic [31:0] rnd = 32'hE84E82E5;
	logic [7:0] refm [logic [23:0]];
	logic [31:0] exq [$];
	int n_fail, tests_run;

	cbc_bus_cycle DUT (.clk_in(clk_in), .srst_in(srst_in), .req_valid_in(rq_v),
		.req_kind_in(rq_k), .req_addr_in(rq_a), .req_word_in(rq_w), .req_copro_in(rq_cp),
		.req_wdata_in(rq_d), .req_ready_out(rq_rdy), .rsp_valid_out(rs_v), .rsp_rdata_out(rs_d),
		.address_strobe_n_out(ads_n), .upper_address_lines_out(ua),
		.high_byte_enable_n_out(hbe_n), .low_byte_enable_n_out(lbe_n), .w_r_out(w_r),
		.d_c_out(d_c), .m_io_out(m_io), .lock_n_out(lock_n), .hold_acknowledge_out(hold_acknowledge),
		.bus_oe_out(bus_oe), .data_lines_in(dq_i), .data_lines_out(dq_o),
		.data_lines_oe_out(dq_oe), .ready_n_in(rdy_n), .next_address_request_n_in(na_n),
		.hold_request_in(hold), .bus_float_input_n_in(flt_n));
	cbc_partner u_far (.clk_in(clk_in), .srst_in(srst_in), .ads_n_in(ads_n), .addr_in(ua),
		.be_n_in({hbe_n, lbe_n}), .w_r_in(w_r), .d_c_in(d_c), .dq_in(dq_o), .dq_oe_in(dq_oe),
		.wait_in(wt), .ready_n_out(rdy_n), .dq_out(dq_i), .err_out(p_err));

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr

	function automatic logic [7:0] ref_b(input logic [23:0] a);
		return refm.exists(a) ? refm[a] : (a[7:0] ^ 8'h5A);
	endfunction : ref_b

	task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			n_fail++;
			$display("[ERR] %s expected %h seen %h", s, e, g);
		end
	endtask : chk

	task end_of_test;
		if (n_fail == 0 && tests_run > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : end_of_test

	task guard(input int i);
		if (i >= 900) begin
			n_fail++;
			$display("[ERR] wait expected done seen timeout");
			end_of_test();
		end
	endtask : guard

	task do_reset;
		srst_in <= 1'b1;
		repeat (16) @(posedge clk_in);
		chk("reset pins", 32'hFFFFFF14, {ads_n, ua, hbe_n, lbe_n, w_r, d_c, m_io, lock_n, hold_acknowledge, dq_oe});
		chk("reset slot", 32'h0, {30'h0, rq_rdy, rs_v});
		srst_in <= 1'b0;
		hold <= 1'b0;
		exq.delete();
		@(posedge clk_in);
	endtask : do_reset

	task automatic issue(input logic [2:0] k, input logic [23:0] a, input logic w,
		input logic cp, input logic [15:0] d);
		int i;
		logic [15:0] m;
		m = (k <= 3'h1) ? (w ? 16'hFFFF : 16'h00FF) : 16'h0000;
		exq.push_back({m & {ref_b(a + 24'h1), ref_b(a)}, m});
		if (k == 3'h2 || k == 3'h3) begin
			refm[a] = d[7:0];
			if (w) refm[a + 24'h1] = d[15:8];
		end
		rq_v <= 1'b1;
		rq_k <= k;
		rq_a <= a;
		rq_w <= w;
		rq_cp <= cp;
		rq_d <= d;
		i = 0;
		do begin
			@(posedge clk_in);
			i++;
		end while (rq_rdy !== 1'b1 && i < 900);
		guard(i);
		rq_v <= 1'b0;
		@(posedge clk_in);
	endtask : issue

	task automatic drain;
		int i;
		i = 0;
		while (exq.size() > 0 && i < 900) begin
			@(posedge clk_in);
			i++;
		end
		guard(i);
	endtask : drain

	task automatic look(input logic [2:0] k, input logic [23:0] a, input logic cp,
		input logic [23:0] ea);
		int i;
		issue(k, a, 1'b1, cp, 16'h5AC3);
		i = 0;
		while (ads_n !== 1'b0 && i < 900) begin
			@(posedge clk_in);
			i++;
		end
		guard(i);
		chk("definition", {28'h0, DEF_TAB[k*4 +: 4]}, {28'h0, m_io, d_c, w_r, lock_n});
		if (k < 3'h6) chk("address", {9'h0, ea[23:1]}, {9'h0, ua});
		chk("enables", {30'h0, 1'b0, ea[0]}, {30'h0, hbe_n, lbe_n});
		drain();
	endtask : look

	always @(posedge clk_in) begin : mon
		logic [31:0] x;
		if (srst_in === 1'b0 && rs_v === 1'b1) begin
			x = 32'hFFFF0000;
			if (exq.size() > 0) x = exq.pop_front();
			chk("read data", {16'h0, x[31:16]}, {16'h0, rs_d & x[15:0]});
		end
	end

	always @(posedge clk_in) begin
		rnd <= lfsr(rnd);
		na_n <= rnd[3] & rnd[9];
		wt <= rnd[6:5];
	end

	initial begin
		clk_in = 1'b0;
		forever #2.5 clk_in = ~clk_in;
	end

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin : main
		int i;
		n_fail = 0;
		tests_run = 0;
		{srst_in, flt_n} = 2'b11;
		{rq_v, rq_k, rq_a, rq_w, rq_cp, rq_d, hold} = '0;
		do_reset();
		for (int k = 0; k < 8; k++) look(k[2:0], 24'hAB1234, 1'b0, k >= 4 ? 24'h001234 : 24'hAB1234);
		look(3'h4, 24'h000005, 1'b1, 24'h8000FD);
		issue(3'h0, 24'h000102, 1'b1, 1'b0, 16'h0000);
		hold <= 1'b1;
		repeat (3) @(posedge clk_in);
		do_reset();
		flt_n <= 1'b0;
		repeat (3) @(posedge clk_in);
		chk("float", 32'h0, {30'h0, bus_oe, dq_oe});
		flt_n <= 1'b1;
		hold <= 1'b1;
		i = 0;
		while (hold_acknowledge !== 1'b1 && i < 900) begin
			@(posedge clk_in);
			i++;
		end
		guard(i);
		repeat (8) begin
			@(posedge clk_in);
			chk("hold", 32'h3, {30'h0, hold_acknowledge, ads_n});
		end
		hold <= 1'b0;
		issue(3'h2, 24'h00010F, 1'b1, 1'b0, 16'hA55A);
		issue(3'h0, 24'h00010F, 1'b1, 1'b0, 16'h0000);
		repeat (150) issue({1'b0, rnd[1:0]}, {16'h0001, 4'h0, rnd[11:8]}, rnd[12], 1'b0, rnd[31:16]);
		drain();
		chk("far side", 32'h0, {24'h0, p_err});
		end_of_test();
	end
endmodule : testbench
